// ### hw/adc_control_and_result_regs.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Operation
// - a 12-bit result is held in a high and a low byte register
// - justification 0: high byte bits 11..4, low upper nibble bits 3..0
// - justification 1: low byte bits 7..0, high lower nibble bits 11..8
// - result bit positions without a result bit read as zero
// - while disabled, both result registers keep their last value
// - conversion starts only on start written high then low
// - busy rises to one when the start sequence completes
// - busy clears to zero once the conversion has finished
// - busy is read-only; writes to its position are ignored
// - clearing enable powers the converter down
// - channel codes 0..11 route inputs 0..11; 12..15 select none
// - internal and external select together pick the single source
// - a pin assigned as converter input loses its shared function
// - a pin assigned as converter input loses its pull-high
// - each control register is eight bits wide
// - clock field divides system clock by two to the code power
// - an internal source disconnects the external channel path
module adc_control_and_result_regs (
	input wire logic CLK_SYS, // system clock
	input wire logic NRST, // async reset, active low
	input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_AWADDR, // write addr
	input wire logic S_AXI_AWVALID, // write addr valid
	output logic S_AXI_AWREADY, // write addr ready
	input wire logic [adc_ctrl_pkg::DATA_W-1:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_ARADDR, // read addr
	input wire logic S_AXI_ARVALID, // read addr valid
	output logic S_AXI_ARREADY, // read addr ready
	output logic [adc_ctrl_pkg::DATA_W-1:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	output logic IRQ, // level interrupt
	output logic CONV_POWER_EN, // converter analog power
	output logic CONV_START, // one-cycle launch pulse to core
	output logic CONV_CLK_TICK, // conversion clock enable pulse
	input wire logic CONV_DONE, // core finished, one-cycle pulse
	input wire logic [adc_ctrl_pkg::RES_W-1:0] CONV_DATA, // core result
	output logic [3:0] INT_SRC_SEL, // internal source code to mux
	output logic [adc_ctrl_pkg::NUM_CH-1:0] EXT_CH_ONEHOT, // channel switch
	input wire logic [adc_ctrl_pkg::NUM_CH-1:0] PIN_ANALOG_SEL, // pin mux
	input wire logic [adc_ctrl_pkg::NUM_CH-1:0] PIN_PULLUP_REQ, // pull-high
	output logic [adc_ctrl_pkg::NUM_CH-1:0] PIN_DIGITAL_EN, // shared fn on
	output logic [adc_ctrl_pkg::NUM_CH-1:0] PIN_PULLUP_EN // pull-high on
);
	import adc_ctrl_pkg::*;

	function automatic logic [6:0] div_mask(input logic [2:0] code);
		div_mask = 7'((8'h01 << code) - 8'h01);
	endfunction

	function automatic logic int_source(input logic [3:0] code);
		// 0000, 0100 and 11xx leave the external channel path in use
		int_source = !(code == 4'h0 || code == 4'h4 || code[3:2] == 2'h3);
	endfunction

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
		reg_mapped = addr == OFS_CTRL0 || addr == OFS_CTRL1 ||
			addr == OFS_RES_HI || addr == OFS_RES_LO ||
			addr == OFS_IRQ_STAT || addr == OFS_IRQ_MASK;
	endfunction

	// reset release
	logic rst_meta_r;
	logic rst_n_r;

	// bus handshake state
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [ADDR_W-1:0] araddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic bvalid_r;
	logic rvalid_r;
	logic [1:0] bresp_r;
	logic [1:0] rresp_r;
	logic [DATA_W-1:0] rdata_r;

	// control register fields
	logic start_r;
	logic start_prev_r;
	logic en_r;
	logic just_r;
	logic [3:0] ch_r;
	logic [3:0] ins_r;
	logic [2:0] cks_r;

	// conversion sequencing
	logic busy_r;
	conv_state_type state_r;
	logic [RES_W-1:0] result_r;
	logic [6:0] div_cnt_r;
	logic tick_r;
	logic launch_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;

	// decode and read mux
	logic do_write;
	logic do_read;
	logic wr_ok;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic start_seq;
	logic [7:0] rd_byte;
	logic rd_ok;

	// reset asserts at once but releases in step with the clock
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// write channel: address and data may arrive in either order
	// readies are combinational so an idle slave takes a beat at once
	assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY = !w_held_r && !bvalid_r;
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	// result registers answer okay but ignore the data
	assign wr_ok = reg_mapped(awaddr_r);

	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wbyte_r <= '0;
			wlane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_r <= 1'b1;
				awaddr_r <= {S_AXI_AWADDR[ADDR_W-1:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_r <= 1'b1;
				wbyte_r <= S_AXI_WDATA[7:0];
				wlane_r <= S_AXI_WSTRB[0];
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;

	// control registers; result registers ignore writes
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			start_r <= CTRL0_RST[C0_START];
			en_r <= CTRL0_RST[C0_EN];
			just_r <= CTRL0_RST[C0_JUST];
			ch_r <= CTRL0_RST[C0_CH_LSB +: 4];
			ins_r <= CTRL1_RST[C1_INS_LSB +: 4];
			cks_r <= CTRL1_RST[C1_CKS_LSB +: 3];
			irq_mask_r <= '0;
		end else if (do_write && wlane_r) begin
			unique case (awaddr_r)
				OFS_CTRL0: begin
					// busy position is not stored from the bus
					start_r <= wbyte_r[C0_START];
					en_r <= wbyte_r[C0_EN];
					just_r <= wbyte_r[C0_JUST];
					ch_r <= wbyte_r[C0_CH_LSB +: 4];
				end
				OFS_CTRL1: begin
					ins_r <= wbyte_r[C1_INS_LSB +: 4];
					cks_r <= wbyte_r[C1_CKS_LSB +: 3];
				end
				OFS_IRQ_MASK: irq_mask_r <= wbyte_r[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// launch on high-then-low of the start bit; ignored when disabled
	// or already converting, so a second sequence cannot corrupt a result
	assign start_seq = start_prev_r && !start_r;

	// previous start value for the high-then-low detector
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			start_prev_r <= 1'b0;
		end else begin
			start_prev_r <= start_r;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= CONV_IDLE;
			busy_r <= 1'b0;
			launch_r <= 1'b0;
		end else begin
			launch_r <= 1'b0;
			unique case (state_r)
				CONV_IDLE: begin
					if (start_seq && en_r) begin
						state_r <= CONV_RUN;
						busy_r <= 1'b1;
						launch_r <= 1'b1;
					end
				end
				CONV_RUN: begin
					// disabling aborts; powering down stops the core
					if (CONV_DONE || !en_r) begin
						state_r <= CONV_IDLE;
						busy_r <= 1'b0;
					end
				end
				default: begin
					state_r <= CONV_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// result loads in the same edge that busy falls
	// an aborted run never loads, so the old value survives
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			result_r <= '0;
		end else if (state_r == CONV_RUN && CONV_DONE && en_r) begin
			result_r <= CONV_DATA;
		end
	end

	// conversion clock: tick once every 2**code system clocks
	// a code change takes effect at once, as the running count is compared under the new mask
	// tick is registered so the core sees a clean one-cycle enable
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (!en_r) begin
			div_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			if ((div_cnt_r & div_mask(cks_r)) == div_mask(cks_r)) begin
				div_cnt_r <= '0;
				tick_r <= 1'b1;
			end else begin
				div_cnt_r <= div_cnt_r + 7'h01;
				tick_r <= 1'b0;
			end
		end
	end

	// completion interrupt; a new event wins over a same-cycle clear
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_stat_r <= '0;
		end else begin
			if (do_write && wlane_r && awaddr_r == OFS_IRQ_STAT) begin
				irq_stat_r[IRQ_DONE] <= irq_stat_r[IRQ_DONE] &
					~wbyte_r[IRQ_DONE];
			end
			if (state_r == CONV_RUN && CONV_DONE && en_r) begin
				irq_stat_r[IRQ_DONE] <= 1'b1;
			end
		end
	end

	// the mask only gates the pin; status records every finish
	assign IRQ = |(irq_stat_r & irq_mask_r);

	// result byte layout by justification, unused bits zero
	always_comb begin
		if (just_r) begin
			res_hi = {4'h0, result_r[11:8]};
			res_lo = result_r[7:0];
		end else begin
			res_hi = result_r[11:4];
			res_lo = {result_r[3:0], 4'h0};
		end
	end

	assign ctrl0 = {start_r, busy_r, en_r, just_r, ch_r};
	assign ctrl1 = {ins_r, 1'b0, cks_r} & CTRL1_MASK;

	// unmapped reads answer zero with an error response
	always_comb begin
		rd_ok = 1'b1;
		unique case (araddr_r)
			OFS_CTRL0: rd_byte = ctrl0;
			OFS_CTRL1: rd_byte = ctrl1;
			OFS_RES_HI: rd_byte = res_hi;
			OFS_RES_LO: rd_byte = res_lo;
			OFS_IRQ_STAT: rd_byte = 8'(irq_stat_r);
			OFS_IRQ_MASK: rd_byte = 8'(irq_mask_r);
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// read path: address captured, data answered the next cycle
	logic ar_held_r;
	assign S_AXI_ARREADY = !ar_held_r && !rvalid_r;
	assign do_read = ar_held_r && !rvalid_r;

	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ar_held_r <= 1'b0;
			araddr_r <= '0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				ar_held_r <= 1'b1;
				araddr_r <= {S_AXI_ARADDR[ADDR_W-1:2], 2'b00};
			end
			if (do_read) begin
				ar_held_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= {24'h000000, rd_byte};
				rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && S_AXI_RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

	// analog routing: one converter, one source at a time
	// codes above the last channel leave the input floating
	always_comb begin
		EXT_CH_ONEHOT = '0;
		if (en_r && !int_source(ins_r) && ch_r <= CH_LAST)
			EXT_CH_ONEHOT[ch_r] = 1'b1;
	end

	assign INT_SRC_SEL = en_r ? ins_r : 4'h0;
	assign CONV_POWER_EN = en_r;
	assign CONV_START = launch_r;
	assign CONV_CLK_TICK = tick_r;

	// pin gating follows the pin mux even while the converter is off
	assign PIN_DIGITAL_EN = ~PIN_ANALOG_SEL;
	assign PIN_PULLUP_EN = PIN_PULLUP_REQ & ~PIN_ANALOG_SEL;
endmodule

// ### hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RES_W = 12;
	localparam int NUM_CH = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RES_HI = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RES_LO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

	// converter_control_0 fields
	localparam int C0_START = 7;
	localparam int C0_BUSY = 6;
	localparam int C0_EN = 5;
	localparam int C0_JUST = 4;
	localparam int C0_CH_LSB = 0;
	// converter_control_1 fields
	localparam int C1_INS_LSB = 4;
	localparam int C1_CKS_LSB = 0;

	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL1_MASK = 8'hF7;
	localparam logic [3:0] CH_LAST = 4'hB;
	localparam int IRQ_W = 1;
	localparam int IRQ_DONE = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_RUN
	} conv_state_type;
endpackage

// ### test/adc_ctrl_checker.sv
`timescale 1ns/100ps
module adc_ctrl_checker (
	input wire logic CLK_SYS, // clock
	input wire logic NRST, // reset, active low
	input wire logic CONV_POWER_EN, // converter power
	input wire logic CONV_START, // launch pulse
	input wire logic CONV_CLK_TICK, // conversion tick
	input wire logic [3:0] INT_SRC_SEL, // internal source
	input wire logic [11:0] EXT_CH_ONEHOT, // channel switch
	input wire logic [11:0] PIN_ANALOG_SEL, // pin mux
	input wire logic [11:0] PIN_PULLUP_REQ, // pull-high request
	input wire logic [11:0] PIN_DIGITAL_EN, // shared function
	input wire logic [11:0] PIN_PULLUP_EN // pull-high
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	chk_pin_shared: assert property (PIN_DIGITAL_EN == ~PIN_ANALOG_SEL)
		else $error("shared function kept");
	chk_pullup_cut: assert property
		(PIN_PULLUP_EN == (PIN_PULLUP_REQ & ~PIN_ANALOG_SEL))
		else $error("pull-high kept");
	chk_one_source: assert property ($onehot0(EXT_CH_ONEHOT))
		else $error("two channels routed");
	chk_off_quiet: assert property
		(!CONV_POWER_EN |-> EXT_CH_ONEHOT == 12'h000 && INT_SRC_SEL == 4'h0)
		else $error("route while off");
	chk_internal_cut: assert property
		(!(INT_SRC_SEL inside {4'h0, 4'h4, [4'hC:4'hF]}) |-> !EXT_CH_ONEHOT)
		else $error("external path open");
	chk_start_pulse: assert property (CONV_START |=> !CONV_START)
		else $error("start pulse too long");
	chk_start_power: assert property (CONV_START |-> CONV_POWER_EN)
		else $error("start while off");
	chk_tick_idle: assert property (!CONV_POWER_EN [*2] |-> !CONV_CLK_TICK)
		else $error("tick while off");
endmodule

bind adc_control_and_result_regs adc_ctrl_checker i_chk (.*);

// ### test/adc_core_model.sv
`timescale 1ns/100ps
module adc_core_model (
	input wire logic clk, // system clock
	input wire logic start, // launch pulse
	input wire logic tick, // conversion tick
	input wire logic [11:0] sample, // value to convert
	output logic done, // finish pulse
	output logic [11:0] data // result
);
	int cnt = -1;
	initial done = 1'b0;
	initial data = 12'h000;
	// four ticks per conversion, so the clock code sets its length
	always @(posedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (start)
			cnt <= 4;
		else if (tick && cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0) begin
			done <= 1'b1;
			data <= sample;
			cnt <= -1;
		end
	end
endmodule

// ### test/adc_control_and_result_regs_tb_top.sv
`timescale 1ns/100ps
module adc_control_and_result_regs_tb_top;
	import adc_ctrl_pkg::*;
	logic CLK_SYS = 1'b0, NRST = 1'b0, S_AXI_AWVALID = 1'b0;
	logic S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
	logic S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, IRQ, CONV_POWER_EN, CONV_START;
	logic CONV_CLK_TICK, CONV_DONE, aw, w;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat;
	logic [3:0] S_AXI_WSTRB = 4'hF, INT_SRC_SEL;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rrsp, brsp;
	logic [11:0] CONV_DATA, EXT_CH_ONEHOT, PIN_DIGITAL_EN, PIN_PULLUP_EN;
	logic [11:0] PIN_ANALOG_SEL = 12'h000, PIN_PULLUP_REQ = 12'h000;
	logic [11:0] sample = 12'h000;
	int fail_count = 0, n_compared = 0, cyc = 0;

	adc_control_and_result_regs i_dut (.*);
	adc_core_model i_core (.clk(CLK_SYS), .start(CONV_START),
		.tick(CONV_CLK_TICK), .sample(sample), .done(CONV_DONE),
		.data(CONV_DATA));

	always #10 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		aw = 1'b1;
		w = 1'b1;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		while (aw || w) begin
			@(negedge CLK_SYS);
			aw = aw && !S_AXI_AWREADY;
			w = w && !S_AXI_WREADY;
			@(posedge CLK_SYS);
			S_AXI_AWVALID <= aw;
			S_AXI_WVALID <= w;
		end
		do @(negedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
		brsp = S_AXI_BRESP;
		@(posedge CLK_SYS);
		S_AXI_BREADY <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
		@(posedge CLK_SYS);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
		rdat = S_AXI_RDATA;
		rrsp = S_AXI_RRESP;
		@(posedge CLK_SYS);
		S_AXI_RREADY <= 1'b0;
		@(posedge CLK_SYS);
		chk(rdat, e);
	endtask
	task automatic t_regs();
		rc(OFS_CTRL0, 32'h0);
		rc(OFS_CTRL1, 32'h0);
		wr(OFS_CTRL1, 8'hFF);
		rc(OFS_CTRL1, 32'hF7);
		wr(OFS_CTRL0, 8'h40);
		rc(OFS_CTRL0, 32'h0);
		wr(OFS_RES_HI, 8'hFF);
		rc(OFS_RES_HI, 32'h0);
		wr(8'h18, 8'h01);
		chk(brsp, RESP_SLVERR);
		rc(8'h18, 32'h0);
		chk(rrsp, RESP_SLVERR);
	endtask
	task automatic t_conv();
		sample <= 12'hA5C;
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_CTRL1, 8'h07);
		wr(OFS_CTRL0, 8'hA0);
		rc(OFS_CTRL0, 32'hA0);
		wr(OFS_CTRL0, 8'h20);
		rc(OFS_CTRL0, 32'h60);
		for (int i = 0; i < 2000 && IRQ !== 1'b1; i++)
			@(negedge CLK_SYS);
		chk(IRQ, 32'h1);
		rc(OFS_CTRL0, 32'h20);
		rc(OFS_RES_HI, 32'hA5);
		rc(OFS_RES_LO, 32'hC0);
		wr(OFS_CTRL0, 8'h30);
		rc(OFS_RES_HI, 32'h0A);
		rc(OFS_RES_LO, 32'h5C);
		wr(OFS_IRQ_STAT, 8'h01);
		wr(OFS_IRQ_MASK, 8'h00);
		sample <= 12'h3E7;
		wr(OFS_CTRL1, 8'h00);
		wr(OFS_CTRL0, 8'hA0);
		wr(OFS_CTRL0, 8'h20);
		repeat (40) @(posedge CLK_SYS);
		rc(OFS_IRQ_STAT, 32'h1);
		chk(IRQ, 32'h0);
		rc(OFS_RES_HI, 32'h3E);
		wr(OFS_IRQ_STAT, 8'h01);
	endtask
	task automatic t_off();
		sample <= 12'h123;
		wr(OFS_CTRL1, 8'h07);
		wr(OFS_CTRL0, 8'hA0);
		wr(OFS_CTRL0, 8'h20);
		wr(OFS_CTRL0, 8'h00);
		rc(OFS_CTRL0, 32'h0);
		rc(OFS_RES_HI, 32'h3E);
		// stale finish from the aborted run must not land
		wr(OFS_CTRL0, 8'h20);
		repeat (700) @(posedge CLK_SYS);
		rc(OFS_RES_LO, 32'h70);
		rc(OFS_IRQ_STAT, 32'h0);
	endtask
	task automatic t_route();
		for (int c = 0; c < 16; c++) begin
			wr(OFS_CTRL0, 8'h20 | 8'(c));
			@(negedge CLK_SYS);
			chk(EXT_CH_ONEHOT, c < 12 ? 32'h1 << c : 32'h0);
		end
		wr(OFS_CTRL0, 8'h23);
		for (int s = 0; s < 16; s++) begin
			wr(OFS_CTRL1, 8'(s << 4));
			@(negedge CLK_SYS);
			chk(INT_SRC_SEL, s);
			chk(EXT_CH_ONEHOT, s inside {0, 4, [12:15]} ? 8 : 0);
		end
		wr(OFS_CTRL0, 8'h03);
		@(negedge CLK_SYS);
		chk({EXT_CH_ONEHOT, INT_SRC_SEL, CONV_POWER_EN}, 32'h0);
		@(posedge CLK_SYS);
		PIN_ANALOG_SEL <= 12'hA5F;
		PIN_PULLUP_REQ <= 12'h3C3;
		@(negedge CLK_SYS);
		chk(PIN_DIGITAL_EN, 32'h5A0);
		chk(PIN_PULLUP_EN, 32'h180);
	endtask
	task automatic t_tick();
		int n;
		wr(OFS_CTRL0, 8'h20);
		for (int k = 0; k < 8; k++) begin
			wr(OFS_CTRL1, 8'(k));
			repeat (128) @(posedge CLK_SYS);
			n = 0;
			repeat (256) begin
				@(negedge CLK_SYS);
				n += CONV_CLK_TICK;
			end
			chk(n, 256 >> k);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge CLK_SYS);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		t_regs();
		t_conv();
		t_off();
		t_route();
		t_tick();
		end_of_test();
	end
endmodule
